/* File: hdl/interrupt_request_handler.sv */
/*
 * Interrupt request handler: pending flags, enables, two priority levels,
 * call sequencing toward the CPU core and return tracking.
 * Assumes the core pulses instrDone at each instruction end and retiDone with
 * the end of a return_from_interrupt; sources pulse srcEvent for one cycle.
 */
// The implementer's own choices: the placing of the registers and strobed register access.
module interrupt_request_handler
    import irq_handler_pkg::*;
#(
    parameter int NUM_SRC = NUM_SRC_DEF,
    parameter logic [MAX_SRC-1:0] SELF_CLEAR = SELF_CLEAR_DEF
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    // Register port
    input wire reg_req_t regReq,
    output logic [DATA_W-1:0] rdData,
    // Sources
    input wire logic [NUM_SRC-1:0] srcEvent,
    // CPU core
    input wire cpu_status_t cpuStatus,
    output logic callStart,
    output logic [VEC_W-1:0] callVector,
    output logic isrEntry,
    // Interrupt
    output logic irqOut
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [NUM_SRC-1:0] oneHot(input logic [IDX_W-1:0] i);
        return NUM_SRC'(1) << i;
    endfunction : oneHot

    function automatic logic [DATA_W-1:0] widen(input logic [NUM_SRC-1:0] v);
        return DATA_W'(v);
    endfunction : widen

    function automatic logic [VEC_W-1:0] vecOf(input logic [IDX_W-1:0] i);
        return VEC_BASE + VEC_W'(VEC_STEP * VEC_W'(i));
    endfunction : vecOf

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [NUM_SRC-1:0] pend, next_pend;
    logic [NUM_SRC-1:0] enable, next_enable;
    logic [NUM_SRC-1:0] prio, next_prio;
    logic globalEn, next_globalEn;
    logic [EVT_W-1:0] evtStat, next_evtStat;
    logic [EVT_W-1:0] evtMask, next_evtMask;
    logic [DATA_W-1:0] next_rdData;
    logic detValid, next_detValid;
    logic detHigh, next_detHigh;
    logic [IDX_W-1:0] detIdx, next_detIdx;
    logic inSvcLow, next_inSvcLow;
    logic inSvcHigh, next_inSvcHigh;
    seq_state_t seqState, next_seqState;
    logic [2:0] callCnt, next_callCnt;
    logic next_callStart, next_isrEntry;
    logic [VEC_W-1:0] next_callVector;
    logic grant;

    logic [NUM_SRC-1:0] eligible, hiReq, loReq;
    logic hiFound, loFound;
    logic [IDX_W-1:0] hiIdx, loIdx;

    // ----------------------------------------
    // Eligibility and priority
    // ----------------------------------------
    assign eligible = pend & enable & {NUM_SRC{globalEn}};
    assign hiReq = eligible & prio;
    assign loReq = eligible & ~prio;

    prio_pick #(.N(NUM_SRC), .IW(IDX_W)) pickHigh (
        .req(hiReq),
        .found(hiFound),
        .idx(hiIdx)
    );

    prio_pick #(.N(NUM_SRC), .IW(IDX_W)) pickLow (
        .req(loReq),
        .found(loFound),
        .idx(loIdx)
    );

    // Detection stage: one clock of sampling before a call can go out
    always_comb begin
        next_detHigh = hiFound && !inSvcHigh;
        next_detValid = next_detHigh || (loFound && !inSvcHigh && !inSvcLow);
        next_detIdx = next_detHigh ? hiIdx : loIdx;
    end

    // Winner rechecked so a flag cleared during detection is not called
    assign grant = cpuStatus.instrDone && !cpuStatus.retiDone && detValid
                   && seqState == SEQ_IDLE && |(eligible & oneHot(detIdx));

    // ----------------------------------------
    // Register writes and flags
    // ----------------------------------------
    always_comb begin
        logic [NUM_SRC-1:0] swSet;
        logic [NUM_SRC-1:0] swClr;
        logic [NUM_SRC-1:0] hwClr;
        logic [EVT_W-1:0] evts;
        swSet = '0;
        swClr = '0;
        hwClr = '0;
        evts = '0;
        next_enable = enable;
        next_prio = prio;
        next_globalEn = globalEn;
        next_evtMask = evtMask;
        if (regReq.wrStrobe) begin
            unique case (regReq.addr)
                OFF_PEND_SET: swSet = regReq.wrData[NUM_SRC-1:0];
                OFF_PEND_CLR: swClr = regReq.wrData[NUM_SRC-1:0];
                OFF_ENABLE: next_enable = regReq.wrData[NUM_SRC-1:0];
                OFF_CTRL: next_globalEn = regReq.wrData[CTRL_GLOBAL_EN_BIT];
                OFF_PRIO: next_prio = regReq.wrData[NUM_SRC-1:0];
                OFF_EVT_MASK: next_evtMask = regReq.wrData[EVT_W-1:0];
                default: ;
            endcase
        end
        if (grant) begin
            hwClr = oneHot(detIdx) & SELF_CLEAR[NUM_SRC-1:0];
        end
        // Hardware set beats any clear in the same cycle
        next_pend = (pend & ~(swClr | hwClr)) | srcEvent | swSet;
        evts[EVT_CALL_BIT] = grant;
        evts[EVT_RETURN_BIT] = cpuStatus.retiDone;
        evts[EVT_PREEMPT_BIT] = grant && detHigh && inSvcLow;
        next_evtStat = evtStat | evts;
        if (regReq.wrStrobe && regReq.addr == OFF_EVT_STAT) begin
            next_evtStat = (evtStat & ~regReq.wrData[EVT_W-1:0]) | evts;
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always_comb begin
        next_rdData = '0;
        if (regReq.rdStrobe) begin
            unique case (regReq.addr)
                OFF_PEND_SET, OFF_PEND_CLR: next_rdData = widen(pend);
                OFF_ENABLE: next_rdData = widen(enable);
                OFF_CTRL: next_rdData[CTRL_GLOBAL_EN_BIT] = globalEn;
                OFF_PRIO: next_rdData = widen(prio);
                OFF_ACTIVE: begin
                    next_rdData[ACT_LOW_BIT] = inSvcLow;
                    next_rdData[ACT_HIGH_BIT] = inSvcHigh;
                    next_rdData[ACT_CALL_BIT] = seqState == SEQ_CALL;
                    next_rdData[ACT_VEC_LSB +: VEC_W] = callVector;
                end
                OFF_EVT_STAT: next_rdData[EVT_W-1:0] = evtStat;
                OFF_EVT_MASK: next_rdData[EVT_W-1:0] = evtMask;
                default: next_rdData = '0;
            endcase
        end
    end

    // ----------------------------------------
    // Call sequence and service levels
    // ----------------------------------------
    always_comb begin
        next_seqState = seqState;
        next_callCnt = callCnt;
        next_callStart = 1'b0;
        next_isrEntry = 1'b0;
        next_callVector = callVector;
        next_inSvcLow = inSvcLow;
        next_inSvcHigh = inSvcHigh;
        // Return drops the innermost level: low is never entered while high is in service
        if (cpuStatus.retiDone) begin
            if (inSvcHigh) begin
                next_inSvcHigh = 1'b0;
            end else begin
                next_inSvcLow = 1'b0;
            end
        end
        unique case (seqState)
            SEQ_IDLE: begin
                if (grant) begin
                    next_seqState = SEQ_CALL;
                    next_callCnt = CALL_LAST;
                    next_callStart = 1'b1;
                    next_callVector = vecOf(detIdx);
                    if (detHigh) begin
                        next_inSvcHigh = 1'b1;
                    end else begin
                        next_inSvcLow = 1'b1;
                    end
                end
            end
            SEQ_CALL: begin
                // Core spends the call cycles; entry marked on the last
                if (callCnt == 3'h0) begin
                    next_seqState = SEQ_IDLE;
                    next_isrEntry = 1'b1;
                end else begin
                    next_callCnt = callCnt - 3'h1;
                end
            end
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pend <= '0;
            enable <= ENABLE_RST[NUM_SRC-1:0];
            prio <= PRIO_RST[NUM_SRC-1:0];
            globalEn <= GLOBAL_EN_RST;
            evtStat <= '0;
            evtMask <= EVT_MASK_RST;
            rdData <= '0;
            detValid <= 1'b0;
            detHigh <= 1'b0;
            detIdx <= '0;
            inSvcLow <= 1'b0;
            inSvcHigh <= 1'b0;
            seqState <= SEQ_IDLE;
            callCnt <= 3'h0;
            callStart <= 1'b0;
            callVector <= 16'h0000;
            isrEntry <= 1'b0;
        end else if (clkEn) begin
            pend <= next_pend;
            enable <= next_enable;
            prio <= next_prio;
            globalEn <= next_globalEn;
            evtStat <= next_evtStat;
            evtMask <= next_evtMask;
            rdData <= next_rdData;
            detValid <= next_detValid;
            detHigh <= next_detHigh;
            detIdx <= next_detIdx;
            inSvcLow <= next_inSvcLow;
            inSvcHigh <= next_inSvcHigh;
            seqState <= next_seqState;
            callCnt <= next_callCnt;
            callStart <= next_callStart;
            callVector <= next_callVector;
            isrEntry <= next_isrEntry;
        end
    end

    // Level output; follows the registered status and mask
    assign irqOut = |(evtStat & evtMask);

endmodule : interrupt_request_handler

/* File: hdl/irq_handler_pkg.sv */
/*
 * Shared constants and carriers for the interrupt request handler:
 * register offsets, field positions, reset values, vector layout, timing counts.
 * Assumes a single 25 MHz system clock and an 8-bit register address.
 */
package irq_handler_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int NUM_SRC_DEF = 15;
    localparam int MAX_SRC = 16;
    localparam int IDX_W = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int VEC_W = 16;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] OFF_PEND_SET = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PEND_CLR = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_PRIO = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_ACTIVE = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_EVT_STAT = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_EVT_MASK = 8'h1C;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_GLOBAL_EN_BIT = 0;
    localparam int ACT_LOW_BIT = 0;
    localparam int ACT_HIGH_BIT = 1;
    localparam int ACT_CALL_BIT = 2;
    localparam int ACT_VEC_LSB = 16;
    localparam int EVT_CALL_BIT = 0;
    localparam int EVT_RETURN_BIT = 1;
    localparam int EVT_PREEMPT_BIT = 2;
    localparam int EVT_W = 3;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [MAX_SRC-1:0] SELF_CLEAR_DEF = 16'h000F;
    localparam logic [MAX_SRC-1:0] ENABLE_RST = 16'h0000;
    localparam logic [MAX_SRC-1:0] PRIO_RST = 16'h0000;
    localparam logic GLOBAL_EN_RST = 1'b0;
    localparam logic [EVT_W-1:0] EVT_MASK_RST = 3'h0;

    // ----------------------------------------
    // Vectors and timing
    // ----------------------------------------
    localparam logic [VEC_W-1:0] VEC_BASE = 16'h0003;
    localparam logic [VEC_W-1:0] VEC_STEP = 16'h0008;
    localparam int CLK_PERIOD_NS = 40;
    localparam int DETECT_CYCLES = 1;
    localparam int CALL_CYCLES = 5;
    localparam int MIN_RESPONSE_CYCLES = 7;
    localparam logic [2:0] CALL_LAST = 3'(CALL_CYCLES - 1);

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [0:0] {
        SEQ_IDLE = 1'b0,
        SEQ_CALL = 1'b1
    } seq_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
        logic wrStrobe;
        logic rdStrobe;
    } reg_req_t;

    typedef struct packed {
        logic instrDone;
        logic retiDone;
    } cpu_status_t;

endpackage : irq_handler_pkg

/* File: hdl/prio_pick.sv */
/*
 * Fixed-order picker: lowest set request index wins.
 * Purely combinational; the caller registers the result.
 */
module prio_pick #(
    parameter int N = 15,
    parameter int IW = 4
) (
    // Requests
    input wire logic [N-1:0] req,
    // Winner
    output logic found,
    output logic [IW-1:0] idx
);

    always_comb begin
        found = 1'b0;
        idx = '0;
        // Walk downward so the lowest index is written last
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                idx = IW'(i);
            end
        end
    end

endmodule : prio_pick

/* File: tb/irq_handler_props.sv */
/* Checker for the interrupt request handler.
   Sees only the top ports; bound after endmodule. */
module irq_handler_props
    import irq_handler_pkg::*;
#(
    parameter int NUM_SRC = NUM_SRC_DEF
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    // Register port
    input wire reg_req_t regReq,
    input wire logic [DATA_W-1:0] rdData,
    // Sources and core
    input wire logic [NUM_SRC-1:0] srcEvent,
    input wire cpu_status_t cpuStatus,
    input wire logic callStart,
    input wire logic [VEC_W-1:0] callVector,
    input wire logic isrEntry,
    input wire logic irqOut
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // ----
    // Call sequencing
    // ----
    chk_call_spacing: assert property (callStart |=> (!callStart)[*4])
        else $error("second call inside a call");
    chk_entry_delay: assert property (callStart |-> ##[4:5] isrEntry)
        else $error("routine entry missing after call");
    chk_entry_cause: assert property (isrEntry |-> $past(callStart, 4) || $past(callStart, 5))
        else $error("routine entry without call");
    chk_entry_pulse: assert property (isrEntry |=> (!isrEntry)[*3])
        else $error("entry pulse repeated");
    chk_call_grant: assert property (callStart |-> $past(cpuStatus.instrDone) && !$past(cpuStatus.retiDone))
        else $error("call not at an instruction end");
    chk_return_from_interrupt_hold: assert property (cpuStatus.retiDone |=> !callStart)
        else $error("call granted on the return edge");
    chk_vector_hold: assert property (!callStart |-> $stable(callVector))
        else $error("vector moved outside a call");
    chk_vector_map: assert property (callStart |-> callVector[2:0] == 3'h3 &&
        callVector < VEC_BASE + VEC_STEP * NUM_SRC)
        else $error("vector off the source table");
endmodule : irq_handler_props

bind interrupt_request_handler irq_handler_props #(.NUM_SRC(NUM_SRC)) props_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn), .regReq(regReq), .rdData(rdData),
    .srcEvent(srcEvent), .cpuStatus(cpuStatus), .callStart(callStart), .callVector(callVector),
    .isrEntry(isrEntry), .irqOut(irqOut));

/* File: tb/cpu_core_model.sv */
/* Behavioural core: ends an instruction every gap+1 cycles.
   Stalls during a call; returns only when a routine is open. */
module cpu_core_model
    import irq_handler_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Bench control
    input wire logic [3:0] gap,
    input wire logic doReti,
    // Handler side
    input wire logic callStart,
    input wire logic isrEntry,
    output cpu_status_t cpuStatus
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt;
    logic [3:0] depth;
    logic calling;
    // Counted, so back-to-back returns are never merged into one
    logic [3:0] retiCount;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 4'h0;
            depth <= 4'h0;
            calling <= 1'b0;
            retiCount <= 4'h0;
            cpuStatus <= '0;
        end else begin
            cpuStatus <= '0;
            retiCount <= retiCount + 4'(doReti);
            if (callStart) begin
                calling <= 1'b1;
            end
            if (isrEntry) begin
                calling <= 1'b0;
                depth <= depth + 4'h1;
            end
            // No instruction ends while the call is pushing
            if (calling || callStart) begin
                cnt <= gap;
            end else if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else begin
                cnt <= gap;
                cpuStatus.instrDone <= 1'b1;
                if (retiCount != 4'h0 && depth != 4'h0) begin
                    cpuStatus.retiDone <= 1'b1;
                    retiCount <= retiCount + 4'(doReti) - 4'h1;
                    depth <= depth - 4'h1;
                end
            end
        end
    end
endmodule : cpu_core_model

/* File: tb/interrupt_request_handler_tb.sv */
/* Self-checking bench for the interrupt request handler.
   Drives registers, sources and a core model; clkEn held high except around one source pulse. */
module interrupt_request_handler_tb
    import irq_handler_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    reg_req_t regReq = '0;
    logic [14:0] srcEvent = 15'h0000;
    logic [3:0] gap = 4'h3;
    logic doReti = 1'b0;
    logic clkEn = 1'b1;
    cpu_status_t cpuStatus;
    logic [DATA_W-1:0] rdData;
    logic callStart;
    logic isrEntry;
    logic irqOut;
    logic [VEC_W-1:0] callVector;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    int lat;
    int hits;
    always #20 sys_clk = ~sys_clk;
    interrupt_request_handler interrupt_request_handler_i (.sys_clk(sys_clk), .reset_n(reset_n),
        .clkEn(clkEn), .regReq(regReq), .rdData(rdData), .srcEvent(srcEvent), .cpuStatus(cpuStatus),
        .callStart(callStart), .callVector(callVector), .isrEntry(isrEntry), .irqOut(irqOut));
    cpu_core_model cpu_core_model_i (.sys_clk(sys_clk), .reset_n(reset_n), .gap(gap), .doReti(doReti),
        .callStart(callStart), .isrEntry(isrEntry), .cpuStatus(cpuStatus));
    // ----
    // Tasks
    // ----
    task automatic close_out();
        if (err_total == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk) regReq <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk) regReq <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk) regReq <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge sys_clk) regReq <= '0;
        #1 cmp(rdData, exp);
    endtask : rd
    task automatic pulse(input int i);
        @(posedge sys_clk) srcEvent <= 15'h0001 << i;
        @(posedge sys_clk) srcEvent <= 15'h0000;
    endtask : pulse
    task automatic return_from_interrupt();
        @(posedge sys_clk) doReti <= 1'b1;
        @(posedge sys_clk) doReti <= 1'b0;
    endtask : return_from_interrupt
    task automatic waitCall(input int i);
        lat = 0;
        while (callStart !== 1'b1 && lat < 80) begin
            @(posedge sys_clk) #1 lat++;
        end
        cmp(32'(callVector), 32'(VEC_BASE + VEC_STEP * i));
        while (isrEntry !== 1'b1 && lat < 90) begin
            @(posedge sys_clk) #1 lat++;
        end
        cmp(32'(isrEntry), 32'h1);
    endtask : waitCall
    task automatic noCall(input int n);
        hits = 0;
        repeat (n) begin
            @(posedge sys_clk) #1 hits += int'(callStart === 1'b1);
        end
        cmp(32'(hits), 32'h0);
    endtask : noCall
    // Software clears its flag, then returns
    task automatic done(input int i);
        wr(OFF_PEND_CLR, 32'h1 << i);
        return_from_interrupt();
    endtask : done
    // ----
    // Sequence
    // ----
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(OFF_ENABLE, 32'h0);
        rd(OFF_CTRL, 32'h0);
        rd(OFF_PRIO, 32'h0);
        rd(8'h40, 32'h0);
        pulse(5);
        noCall(20);
        rd(OFF_PEND_SET, 32'h20);
        wr(OFF_ENABLE, 32'h0EF6);
        noCall(10);
        wr(OFF_CTRL, 32'h1);
        waitCall(5);
        rd(OFF_PEND_SET, 32'h20);
        rd(OFF_EVT_STAT, 32'h1);
        rd(OFF_ACTIVE, 32'h002B0001);
        cmp(32'(irqOut), 32'h0);
        wr(OFF_EVT_MASK, 32'h1);
        #1 cmp(32'(irqOut), 32'h1);
        wr(OFF_EVT_STAT, 32'h1);
        #1 cmp(32'(irqOut), 32'h0);
        done(5);
        noCall(20);
        pulse(6);
        waitCall(6);
        return_from_interrupt();
        waitCall(6);
        done(6);
        noCall(20);
        pulse(1);
        waitCall(1);
        rd(OFF_PEND_SET, 32'h0);
        return_from_interrupt();
        wr(OFF_PEND_SET, 32'h4);
        waitCall(2);
        return_from_interrupt();
        wr(OFF_CTRL, 32'h0);
        wr(OFF_PRIO, 32'h0E00);
        pulse(4);
        pulse(2);
        pulse(9);
        wr(OFF_CTRL, 32'h1);
        waitCall(9);
        done(9);
        waitCall(2);
        return_from_interrupt();
        waitCall(4);
        done(4);
        pulse(7);
        waitCall(7);
        pulse(10);
        waitCall(10);
        rd(OFF_ACTIVE, 32'h00530003);
        rd(OFF_EVT_STAT, 32'h7);
        pulse(11);
        noCall(20);
        done(10);
        waitCall(11);
        done(11);
        done(7);
        gap <= 4'h0;
        noCall(20);
        @(posedge sys_clk) srcEvent <= 15'h0002;
        lat = 0;
        while (isrEntry !== 1'b1 && lat < 20) begin
            @(posedge sys_clk) #1 lat++;
            srcEvent <= 15'h0000;
        end
        cmp(32'(lat >= MIN_RESPONSE_CYCLES && lat <= MIN_RESPONSE_CYCLES + 1), 32'h1);
        return_from_interrupt();
        @(posedge sys_clk) clkEn <= 1'b0;
        pulse(3);
        @(posedge sys_clk) clkEn <= 1'b1;
        rd(OFF_PEND_SET, 32'h0);
        close_out();
    end
endmodule : interrupt_request_handler_tb
